// ==== verilog/bri_pkg.sv ====
// Purpose: shared constants for the bypass relay and input logic
// Assumes: 250 MHz hclk, AHB-Lite register access
// Notes: function codes index the relay condition vector
package bri_pkg;
  localparam int BRI_NUM_DI = 5;
  localparam int BRI_NUM_RLY = 5;
  localparam int BRI_CODE_W = 5;
  localparam int BRI_NUM_COND = 25;
  // register byte offsets
  localparam logic [7:0] BRI_OFF_INCFG = 8'h00;
  localparam logic [7:0] BRI_OFF_COMMIN = 8'h04;
  localparam logic [7:0] BRI_OFF_CMD = 8'h08;
  localparam logic [7:0] BRI_OFF_RLYSEL = 8'h0C;
  localparam logic [7:0] BRI_OFF_STAT = 8'h10;
  // command register bits
  localparam int BRI_CMD_ON = 0;
  localparam int BRI_CMD_OFF = 1;
  // contact input slots; slot 5 (smoke) is fixed, not programmable
  localparam int BRI_DI_START = 0;
  localparam int BRI_DI_PERMIT = 1;
  localparam int BRI_DI_LOCK = 2;
  localparam int BRI_DI_FRESET = 3;
  localparam int BRI_DI_OVR2 = 4;
  localparam int BRI_DI_SMOKE = 5;
  // level taken by an input that is not selected
  localparam logic [4:0] BRI_NOSEL_LEVEL = 5'h06;
  // reset values
  localparam logic [31:0] BRI_INCFG_RST = 32'h0000_0000;
  localparam logic [31:0] BRI_RLYSEL_RST = {7'h00, 5'h17, 5'h06, 5'h03, 5'h02, 5'h01};
  // relay function codes
  localparam int C_READY = 1, C_RUN = 2, C_START = 3, C_BYSEL = 4, C_BYRUN = 5,
    C_BYFLT = 6, C_BYOK = 7, C_BYWRN = 8, C_DRFLT = 9, C_DROK = 10, C_DRWRN = 11,
    C_OVRD = 12, C_BYHAND = 13, C_BYOFF = 14, C_BYAUTO = 15, C_COMM = 16,
    C_WRN = 17, C_BYFW = 18, C_BYOVL = 19, C_BYUNL = 20, C_HOT = 21, C_UNL = 22,
    C_FLT = 23, C_FW = 24;
  // timing
  localparam longint BRI_CLK_HZ = 250_000_000;
  localparam longint BRI_COOL_S = 180;
  localparam logic [39:0] BRI_COOL_CYC = 40'(BRI_COOL_S * BRI_CLK_HZ);
  localparam longint BRI_BLINK_MS = 250;
  localparam logic [31:0] BRI_BLINK_CYC = 32'(BRI_BLINK_MS * (BRI_CLK_HZ / 1000));
  typedef enum logic [1:0] {
    BRI_SRC_DIRECT = 2'h0,
    BRI_SRC_NONE = 2'h1,
    BRI_SRC_COMM = 2'h2
  } bri_src_t;
  typedef enum logic [2:0] {
    BRI_BF_OK = 3'h1,
    BRI_BF_FAULT = 3'h2,
    BRI_BF_COOL = 3'h4
  } bri_bf_t;
endpackage : bri_pkg

// ==== verilog/bri_relay_if.sv ====
// Purpose: carries relay conditions and codes between top and relay mapper
// Assumes: one clock domain
// Notes: cond index equals the relay function code
`timescale 1ns/1ps
interface bri_relay_if;
  import bri_pkg::*;
  logic [BRI_NUM_COND-1:0] cond;
  logic [BRI_NUM_RLY-1:0][BRI_CODE_W-1:0] codes;
  logic [BRI_NUM_RLY-1:0] relay;
  modport top (output cond, output codes, input relay);
  modport map (input cond, input codes, output relay);
endinterface : bri_relay_if

// ==== verilog/bri_relay_map.sv ====
// Purpose: picks each relay's condition by its stored function code
// Assumes: cond[0] and unknown codes mean relay off
// Notes: relay states are registered
`timescale 1ns/1ps
module bri_relay_map
  import bri_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // conditions and codes in, relays out
  bri_relay_if.map rif
);
  import bri_pkg::*;

  logic [BRI_NUM_RLY-1:0] relay;
  logic [BRI_NUM_RLY-1:0] next_relay;

  function automatic logic pick(input logic [BRI_NUM_COND-1:0] c,
                                input logic [BRI_CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    if (int'(code) < BRI_NUM_COND)
    begin
      hit = c[code];
    end
    return hit;
  endfunction : pick

  always_comb
  begin
    for (int i = 0; i < BRI_NUM_RLY; i++)
    begin
      next_relay[i] = pick(rif.cond, rif.codes[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      relay <= '0;
    end
    else
    begin
      relay <= next_relay;
    end
  end

  assign rif.relay = relay;
endmodule : bri_relay_map

// ==== verilog/bri_top.sv ====
// Purpose: contact input conditioning and relay function logic
// Assumes: field and state inputs synchronous to hclk; AHB-Lite slave
// Notes: zero wait state slave, response always OKAY
// Behaviour
// - programmable inputs: direct, not selected, comms
// - not selected: no action, still reported
// - comms: act on comms, contact still reported
// - start/stop runs drive or bypass in auto
// - open permissive with start: flash green, inhibit
// - open interlock: red, drop contactors and started
// - fault reset clears; refused during overload cooling
// - override 2, smoke override 1, reverse selection
// - code 1: interlocks closed, selected mode fault-free
// - code 2: motor running from any source
// - code 3: start, interlocks closed, no fault
// - code 4 bypass selected, 5 bypass running
// - code 6 bypass fault, 7 no bypass fault with power ok
// - code 9 drive fault, 10 no drive fault with power ok
// - codes 8, 11, 17 warnings
// - code 12: either override selected
// - codes 13 hand run, 14 off, 15 auto
// - code 16 set/cleared by comms commands
// - codes 23, 18, 24 fault/warning combinations
// - codes 19 overload, 20, 22 underload
// - code 21 board over temperature
// - five programmable inputs, one fixed, five relays
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module bri_top
  import bri_pkg::*;
#(
  parameter logic [39:0] COOL_CYCLES = BRI_COOL_CYC,
  parameter logic [31:0] BLINK_CYCLES = BRI_BLINK_CYC
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // field contacts
  input wire logic [bri_pkg::BRI_NUM_DI:0] contact_input,
  input wire logic reverse_contact,
  input wire logic power_ok,
  // drive and bypass state
  input wire logic bypass_sel,
  input wire logic drive_auto,
  input wire logic byp_hand,
  input wire logic byp_auto,
  input wire logic byp_off,
  input wire logic drive_running,
  input wire logic bypass_running,
  input wire logic drive_fault,
  input wire logic drive_warn,
  input wire logic drive_underload,
  input wire logic byp_fault_evt,
  input wire logic byp_warn,
  input wire logic byp_ovl_trip,
  input wire logic byp_unl_trip,
  input wire logic byp_overload,
  input wire logic byp_underload,
  input wire logic board_hot,
  // control outputs
  output logic drive_start,
  output logic drive_contactor,
  output logic bypass_contactor,
  output logic led_green,
  output logic led_red,
  output logic override1_sel,
  output logic override2_sel,
  output logic reverse_sel,
  output logic byp_fault_latched,
  output logic [bri_pkg::BRI_NUM_RLY-1:0] relay_out
);
  import bri_pkg::*;

  bri_relay_if rif ();

  // register file
  logic [31:0] incfg;
  logic [BRI_NUM_DI-1:0] commin;
  logic comm_relay;
  logic [31:0] rlysel;
  logic [7:0] addr_q;
  logic wr_q;
  logic [31:0] next_incfg;
  logic [BRI_NUM_DI-1:0] next_commin;
  logic next_comm_relay;
  logic [31:0] next_rlysel;
  logic [7:0] next_addr_q;
  logic next_wr_q;
  logic [31:0] next_hrdata;

  // input conditioning
  logic [BRI_NUM_DI-1:0] eff;
  logic freset_q;
  logic start_any;
  logic lock_ok;
  logic permit_ok;
  logic sys_fault;

  // bypass fault state
  bri_bf_t bf_state;
  bri_bf_t next_bf_state;
  logic [39:0] cool_cnt;
  logic [39:0] next_cool_cnt;

  // indicator blink
  logic [31:0] blink_cnt;
  logic [31:0] next_blink_cnt;
  logic blink;
  logic next_blink;

  // registered control outputs
  logic [8:0] ctl;
  logic [8:0] next_ctl;

  function automatic logic take(input logic [1:0] src, input logic pin,
                                input logic comm, input logic idle);
    logic v;
    v = idle;
    if (src == BRI_SRC_DIRECT)
    begin
      v = pin;
    end
    else if (src == BRI_SRC_COMM)
    begin
      v = comm;
    end
    return v;
  endfunction : take

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : is_reg

  always_comb
  begin
    for (int i = 0; i < BRI_NUM_DI; i++)
    begin
      eff[i] = take(incfg[2*i +: 2], contact_input[i], commin[i],
                    BRI_NOSEL_LEVEL[i]);
    end
  end

  // interlock and permissive open contacts block running
  assign lock_ok = eff[BRI_DI_LOCK];
  assign permit_ok = eff[BRI_DI_PERMIT];
  assign start_any = bypass_sel ? (byp_hand | (byp_auto & eff[BRI_DI_START]))
                                : (drive_auto & eff[BRI_DI_START]);
  assign sys_fault = drive_fault | (bf_state != BRI_BF_OK);

  // bus side: capture address phase, write in data phase
  always_comb
  begin
    next_incfg = incfg;
    next_commin = commin;
    next_comm_relay = comm_relay;
    next_rlysel = rlysel;
    next_addr_q = addr_q;
    next_wr_q = 1'b0;
    next_hrdata = hrdata;
    if (wr_q)
    begin
      if (is_reg(addr_q, BRI_OFF_INCFG))
      begin
        next_incfg = {22'h000000, hwdata[9:0]};
      end
      else if (is_reg(addr_q, BRI_OFF_COMMIN))
      begin
        next_commin = hwdata[BRI_NUM_DI-1:0];
      end
      else if (is_reg(addr_q, BRI_OFF_CMD))
      begin
        // on wins when both bits are written together
        if (hwdata[BRI_CMD_ON])
        begin
          next_comm_relay = 1'b1;
        end
        else if (hwdata[BRI_CMD_OFF])
        begin
          next_comm_relay = 1'b0;
        end
      end
      else if (is_reg(addr_q, BRI_OFF_RLYSEL))
      begin
        next_rlysel = {7'h00, hwdata[24:0]};
      end
    end
    if (hsel && hready && htrans[1])
    begin
      next_addr_q = haddr[7:0];
      next_wr_q = hwrite;
      next_hrdata = 32'h0000_0000;
      if (is_reg(haddr[7:0], BRI_OFF_INCFG))
      begin
        next_hrdata = incfg;
      end
      else if (is_reg(haddr[7:0], BRI_OFF_COMMIN))
      begin
        next_hrdata = {27'h0000000, commin};
      end
      else if (is_reg(haddr[7:0], BRI_OFF_CMD))
      begin
        next_hrdata = {31'h00000000, comm_relay};
      end
      else if (is_reg(haddr[7:0], BRI_OFF_RLYSEL))
      begin
        next_hrdata = rlysel;
      end
      else if (is_reg(haddr[7:0], BRI_OFF_STAT))
      begin
        // raw contacts stay visible whatever the source setting
        next_hrdata = {16'h0000, byp_fault_latched, bf_state, relay_out,
                       reverse_contact, contact_input};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      incfg <= BRI_INCFG_RST;
      commin <= '0;
      comm_relay <= 1'b0;
      rlysel <= BRI_RLYSEL_RST;
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      incfg <= next_incfg;
      commin <= next_commin;
      comm_relay <= next_comm_relay;
      rlysel <= next_rlysel;
      addr_q <= next_addr_q;
      wr_q <= next_wr_q;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // bypass fault latch with overload cooling; new fault beats reset
  always_comb
  begin
    next_bf_state = bf_state;
    next_cool_cnt = cool_cnt;
    case (bf_state)
      BRI_BF_OK:
      begin
        if (byp_ovl_trip)
        begin
          next_bf_state = BRI_BF_COOL;
          next_cool_cnt = COOL_CYCLES;
        end
        else if (byp_fault_evt || byp_unl_trip)
        begin
          next_bf_state = BRI_BF_FAULT;
        end
      end
      BRI_BF_FAULT:
      begin
        if (byp_ovl_trip)
        begin
          next_bf_state = BRI_BF_COOL;
          next_cool_cnt = COOL_CYCLES;
        end
        else if (eff[BRI_DI_FRESET] && !freset_q && !byp_fault_evt && !byp_unl_trip)
        begin
          next_bf_state = BRI_BF_OK;
        end
      end
      BRI_BF_COOL:
      begin
        // resets are refused until the motor has cooled
        if (byp_ovl_trip)
        begin
          next_cool_cnt = COOL_CYCLES;
        end
        else if (cool_cnt <= 40'h00_0000_0001)
        begin
          next_bf_state = BRI_BF_FAULT;
          next_cool_cnt = 40'h00_0000_0000;
        end
        else
        begin
          next_cool_cnt = cool_cnt - 40'h00_0000_0001;
        end
      end
      default:
      begin
        next_bf_state = BRI_BF_FAULT;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bf_state <= BRI_BF_OK;
      cool_cnt <= 40'h00_0000_0000;
      freset_q <= 1'b0;
    end
    else
    begin
      bf_state <= next_bf_state;
      cool_cnt <= next_cool_cnt;
      freset_q <= eff[BRI_DI_FRESET];
    end
  end

  // blink phase for the enabled indicator
  always_comb
  begin
    next_blink_cnt = blink_cnt + 32'h0000_0001;
    next_blink = blink;
    if (blink_cnt >= BLINK_CYCLES - 32'h0000_0001)
    begin
      next_blink_cnt = 32'h0000_0000;
      next_blink = ~blink;
    end
  end

  // control outputs: drive start, contactors, leds, modes
  always_comb
  begin
    next_ctl[0] = !bypass_sel && drive_auto && eff[BRI_DI_START]
                  && lock_ok && permit_ok;
    next_ctl[1] = !bypass_sel && lock_ok;
    next_ctl[2] = bypass_sel && (byp_hand || (byp_auto && eff[BRI_DI_START]))
                  && lock_ok && permit_ok && (bf_state == BRI_BF_OK);
    next_ctl[3] = lock_ok && (permit_ok || (start_any && blink));
    next_ctl[4] = !lock_ok;
    next_ctl[5] = contact_input[BRI_DI_SMOKE];
    next_ctl[6] = eff[BRI_DI_OVR2];
    next_ctl[7] = reverse_contact;
    next_ctl[8] = bf_state != BRI_BF_OK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
      ctl <= 9'h000;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      ctl <= next_ctl;
    end
  end

  assign drive_start = ctl[0];
  assign drive_contactor = ctl[1];
  assign bypass_contactor = ctl[2];
  assign led_green = ctl[3];
  assign led_red = ctl[4];
  assign override1_sel = ctl[5];
  assign override2_sel = ctl[6];
  assign reverse_sel = ctl[7];
  assign byp_fault_latched = ctl[8];

  // relay condition vector, index is the function code
  logic bflt;
  assign bflt = bf_state != BRI_BF_OK;
  always_comb
  begin
    rif.cond = '0;
    rif.cond[C_READY] = lock_ok && !(bypass_sel ? bflt : drive_fault);
    rif.cond[C_RUN] = drive_running || bypass_running;
    rif.cond[C_START] = start_any && lock_ok && !sys_fault;
    rif.cond[C_BYSEL] = bypass_sel;
    rif.cond[C_BYRUN] = bypass_running;
    rif.cond[C_BYFLT] = bflt;
    rif.cond[C_BYOK] = power_ok && !bflt;
    rif.cond[C_BYWRN] = byp_warn;
    rif.cond[C_DRFLT] = drive_fault;
    rif.cond[C_DROK] = power_ok && !drive_fault;
    rif.cond[C_DRWRN] = drive_warn;
    rif.cond[C_OVRD] = contact_input[BRI_DI_SMOKE] || eff[BRI_DI_OVR2];
    rif.cond[C_BYHAND] = bypass_running && byp_hand;
    rif.cond[C_BYOFF] = byp_off;
    rif.cond[C_BYAUTO] = byp_auto;
    rif.cond[C_COMM] = comm_relay;
    rif.cond[C_WRN] = drive_warn || byp_warn;
    rif.cond[C_BYFW] = bflt || byp_warn;
    rif.cond[C_BYOVL] = byp_overload;
    rif.cond[C_BYUNL] = byp_underload;
    rif.cond[C_HOT] = board_hot;
    rif.cond[C_UNL] = drive_underload || byp_underload;
    rif.cond[C_FLT] = sys_fault;
    rif.cond[C_FW] = sys_fault || drive_warn || byp_warn;
  end

  always_comb
  begin
    for (int i = 0; i < BRI_NUM_RLY; i++)
    begin
      rif.codes[i] = rlysel[BRI_CODE_W*i +: BRI_CODE_W];
    end
  end

  bri_relay_map u_map (
    .hclk(hclk),
    .hresetn(hresetn),
    .rif(rif.map)
  );

  assign relay_out = rif.relay;
endmodule : bri_top

// ==== verif/bri_top_props.sv ====
// Purpose: concurrent checks on the bypass relay block ports
// Assumes: one clock domain, active low async reset
// Notes: bound to bri_top; each check save the bus one and the two led_red ones ties an output to its cause
`timescale 1ns/1ps
module bri_top_props
  import bri_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // causes
  input wire logic [bri_pkg::BRI_NUM_DI:0] contact_input,
  input wire logic reverse_contact,
  input wire logic bypass_sel,
  input wire logic drive_auto,
  input wire logic byp_fault_evt,
  // effects
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic drive_start,
  input wire logic drive_contactor,
  input wire logic bypass_contactor,
  input wire logic led_green,
  input wire logic led_red,
  input wire logic override1_sel,
  input wire logic reverse_sel,
  input wire logic byp_fault_latched,
  input wire logic [bri_pkg::BRI_NUM_RLY-1:0] relay_out
);
  import bri_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_red_drops_all: assert property (
    led_red |-> !drive_contactor && !bypass_contactor && !drive_start)
    else $error("motor path held with interlock open");
  a_red_no_green: assert property (led_red |-> !led_green)
    else $error("green and red lit together");
  // first edge after release still shows reset levels, hence the guard
  a_smoke_follow: assert property (
    $past(hresetn) |-> override1_sel == $past(contact_input[5]))
    else $error("smoke override does not follow its contact");
  a_reverse_follow: assert property (
    $past(hresetn) |-> reverse_sel == $past(reverse_contact))
    else $error("reverse selection does not follow its contact");
  a_start_in_drive: assert property (
    drive_start |-> !$past(bypass_sel) && $past(drive_auto))
    else $error("drive started outside drive auto");
  a_fault_latch: assert property (byp_fault_evt |-> ##2 byp_fault_latched)
    else $error("bypass fault not latched");
  a_relays_reset: assert property (
    @(posedge hclk) disable iff (1'b0) !hresetn |-> relay_out == '0)
    else $error("relay energised in reset");
  c_fault_seen: cover property ($rose(byp_fault_latched));
  c_red_seen: cover property (led_red);
  c_drive_run: cover property (drive_start && led_green);
endmodule : bri_top_props

bind bri_top bri_top_props props_u (.hclk, .hresetn, .contact_input, .reverse_contact,
  .bypass_sel, .drive_auto, .byp_fault_evt, .hreadyout, .hresp, .drive_start,
  .drive_contactor, .bypass_contactor, .led_green, .led_red, .override1_sel,
  .reverse_sel, .byp_fault_latched, .relay_out);

// ==== verif/bri_field_model.sv ====
// Purpose: field side: contacts, power and drive/bypass state lines
// Assumes: levels change just after a rising edge
// Notes: st packs the state lines in dut port order
`timescale 1ns/1ps
module bri_field_model
(
  // clock
  input wire logic hclk,
  // lines towards the block
  output logic [5:0] contact_input,
  output logic reverse_contact,
  output logic power_ok,
  output logic [16:0] st
);
  // contacts are plain levels, closed reads high; no bounce is modelled
  task automatic put(input logic [5:0] c, input logic r, input logic [16:0] s);
    @(posedge hclk);
    contact_input <= c;
    reverse_contact <= r;
    st <= s;
  endtask : put
  // supply loss must drop the healthy relays
  task automatic power(input logic p);
    @(posedge hclk);
    power_ok <= p;
  endtask : power
  initial
  begin
    contact_input = 6'h06;
    reverse_contact = 1'b0;
    power_ok = 1'b1;
    st = 17'h00002;
  end
endmodule : bri_field_model

// ==== verif/bri_top_tb_top.sv ====
// Purpose: self-checking bench for the bypass relay and input logic
// Assumes: short cooling and blink counts keep the run brief
// Notes: expected relay levels come from the stimulus held in cs, ss, bf, comm, pw
`timescale 1ns/1ps
module bri_top_tb_top;
  import bri_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, reverse_contact, power_ok;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] contact_input, cs;
  logic [16:0] st, ss;
  logic drive_start, drive_contactor, bypass_contactor, led_green, led_red, bf, comm, pw;
  logic override1_sel, override2_sel, reverse_sel, byp_fault_latched;
  logic [4:0] relay_out;
  int failures, total_checks, n;

  bri_field_model field_u (.hclk, .contact_input, .reverse_contact, .power_ok, .st);
  // cooling and blink would otherwise need seconds of simulated time
  bri_top #(.COOL_CYCLES(40'h14), .BLINK_CYCLES(32'h4)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .contact_input, .reverse_contact, .power_ok,
    .bypass_sel(st[0]), .drive_auto(st[1]), .byp_hand(st[2]), .byp_auto(st[3]),
    .byp_off(st[4]), .drive_running(st[5]), .bypass_running(st[6]), .drive_fault(st[7]),
    .drive_warn(st[8]), .drive_underload(st[9]), .byp_fault_evt(st[10]), .byp_warn(st[11]),
    .byp_ovl_trip(st[12]), .byp_unl_trip(st[13]), .byp_overload(st[14]),
    .byp_underload(st[15]), .board_hot(st[16]), .drive_start, .drive_contactor,
    .bypass_contactor, .led_green, .led_red, .override1_sel, .override2_sel, .reverse_sel,
    .byp_fault_latched, .relay_out);

  always #2 hclk = ~hclk;

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask : cyc

  // no cycle count assumed; only the watchdog ends a stuck wait
  task automatic wait_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask : ahb_write

  task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask : ahb_read

  task automatic field(input logic [5:0] c, input logic r, input logic [16:0] s);
    cs = c;
    ss = s;
    field_u.put(c, r, s);
  endtask : field

  // reset acts on the closing edge only, so the contact opens again at once
  task automatic pulse_reset();
    field(cs | 6'h08, 1'b0, ss);
    field(cs & 6'h37, 1'b0, ss);
    cyc(3);
  endtask : pulse_reset

  function automatic logic exp_cond(input int k);
    logic flt;
    flt = ss[7] | bf;
    case (k)
      1: return cs[2] & !(ss[0] ? bf : ss[7]);
      2: return ss[5] | ss[6];
      3: return cs[0] & cs[2] & !flt;
      4: return ss[0];
      5: return ss[6];
      6: return bf;
      7: return pw & !bf;
      8: return ss[11];
      9: return ss[7];
      10: return pw & !ss[7];
      11: return ss[8];
      12: return cs[5] | cs[4];
      13: return ss[6] & ss[2];
      14: return ss[4];
      15: return ss[3];
      16: return comm;
      17: return ss[8] | ss[11];
      18: return bf | ss[11];
      19: return ss[14];
      20: return ss[15];
      21: return ss[16];
      22: return ss[9] | ss[15];
      23: return flt;
      24: return flt | ss[8] | ss[11];
      default: return 1'b0;
    endcase
  endfunction : exp_cond

  task automatic sweep(input logic [5:0] c, input logic [16:0] s);
    field(c, 1'b0, s);
    for (int b = 1; b <= 21; b += 5)
    begin
      ahb_write(BRI_OFF_RLYSEL, {7'h00, 5'(b + 4), 5'(b + 3), 5'(b + 2), 5'(b + 1), 5'(b)});
      cyc(3);
      for (int k = 0; k < 5; k++)
        check(relay_out[k] === exp_cond(b + k), "relay code level");
    end
    $display("test relay sweep done");
  endtask : sweep

  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    #40000;
    failures++;
    close_out();
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    failures = 0;
    total_checks = 0;
    bf = 1'b0;
    comm = 1'b0;
    pw = 1'b1;
    // a real falling edge, so the asynchronous reset acts before the first clock
    #1;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    check(relay_out === 5'h00 && hreadyout === 1'b1, "outputs in reset");
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    ahb_read(BRI_OFF_RLYSEL, rd);
    check(rd === BRI_RLYSEL_RST, "relay code defaults");
    ahb_read(BRI_OFF_INCFG, rd);
    check(rd === BRI_INCFG_RST, "input source defaults");
    ahb_read(8'h14, rd);
    check(rd === 32'h0, "unmapped read");
    $display("test defaults done");
    field(6'h07, 1'b0, 17'h00002);
    cyc(3);
    check(drive_start === 1'b1, "direct start");
    ahb_write(BRI_OFF_INCFG, 32'h1);
    cyc(3);
    check(drive_start === 1'b0, "unselected start acted on");
    ahb_read(BRI_OFF_STAT, rd);
    check(rd[0] === 1'b1, "unselected contact not reported");
    ahb_write(BRI_OFF_COMMIN, 32'h1);
    ahb_write(BRI_OFF_INCFG, 32'h2);
    field(6'h06, 1'b0, 17'h00002);
    cyc(3);
    check(drive_start === 1'b1, "comms start");
    ahb_read(BRI_OFF_STAT, rd);
    check(rd[0] === 1'b0, "comms contact report");
    ahb_write(BRI_OFF_INCFG, 32'h0);
    field(6'h07, 1'b0, 17'h00009);
    cyc(3);
    check(bypass_contactor === 1'b1 && drive_start === 1'b0, "bypass auto start");
    field(6'h06, 1'b0, 17'h00009);
    cyc(3);
    check(bypass_contactor === 1'b0, "bypass auto stop");
    $display("test input sources done");
    field(6'h05, 1'b0, 17'h00002);
    n = 0;
    repeat (16)
    begin
      @(posedge hclk);
      n += int'(led_green === 1'b1);
    end
    check(n > 2 && n < 14 && drive_start === 1'b0, "permissive flash");
    field(6'h03, 1'b0, 17'h00009);
    cyc(3);
    check(led_red === 1'b1 && bypass_contactor === 1'b0, "lock open bypass");
    check(relay_out[2] === 1'b0, "started relay with lock open");
    field(6'h03, 1'b0, 17'h00002);
    cyc(3);
    check(led_red === 1'b1 && drive_contactor === 1'b0, "lock open drive");
    field(6'h37, 1'b1, 17'h00002);
    cyc(3);
    check({override1_sel, override2_sel, reverse_sel} === 3'h7, "modes set");
    field(6'h07, 1'b0, 17'h00002);
    cyc(3);
    check({override1_sel, override2_sel, reverse_sel} === 3'h0, "modes clear");
    $display("test interlocks and modes done");
    field(6'h07, 1'b0, 17'h01002);
    field(6'h07, 1'b0, 17'h00002);
    cyc(2);
    ahb_read(BRI_OFF_STAT, rd);
    check(rd[14:12] === BRI_BF_COOL, "overload cooling");
    pulse_reset();
    ahb_read(BRI_OFF_STAT, rd);
    check(rd[14:12] === BRI_BF_COOL, "reset taken while cooling");
    cyc(30);
    ahb_read(BRI_OFF_STAT, rd);
    check(rd[14:12] === BRI_BF_FAULT && byp_fault_latched === 1'b1,
          "fault held after cooling");
    pulse_reset();
    check(byp_fault_latched === 1'b0, "fault not cleared");
    $display("test fault reset done");
    sweep(6'h07, 17'h0002A);
    field(6'h07, 1'b0, 17'h0042A);
    field(6'h07, 1'b0, 17'h0002A);
    bf = 1'b1;
    ahb_write(BRI_OFF_CMD, 32'h1);
    comm = 1'b1;
    sweep(6'h33, 17'h1CBFF);
    pulse_reset();
    bf = 1'b0;
    ahb_write(BRI_OFF_CMD, 32'h2);
    comm = 1'b0;
    field_u.power(1'b0);
    pw = 1'b0;
    sweep(6'h05, 17'h0C345);
    close_out();
  end
endmodule : bri_top_tb_top
